// *** core/icl_core_if.sv ***
// tick and synchronised inputs shared by the controller modules
`timescale 1ns/10ps
`include "icl_defines.svh"
interface icl_core_if;
  logic tick;
  logic [`ICL_IN_W-1:0] raw;
  logic [`ICL_IN_W-1:0] ins;
  modport tb (output tick);
  modport sy (input raw, output ins);
  modport core (input tick, ins, output raw);
endinterface : icl_core_if

// *** core/icl_ctrl.sv ***
// interlock teach-in sequencing, safety outputs, diagnostics and leds
// Overview of operation
// - teach start: power off, fault on, 1 Hz
// - after 10 s, 3 Hz bursts ask power-off
// - no power-off in 5 min: abort, code 5
// - learned code activates on next detection
// - single variant pairs once, refuses reteach
// - multi variant reteaches, new code replaces old
// - multi variant: ten minute output inhibit
// - power led blinks through inhibit and detection
// - power loss restarts the inhibit from zero
// - unlock turns both outputs off at once
// - lock with actuator present re-enables outputs
// - warning drops main diagnostic, outputs stay on
// - warning held 30 minutes shuts outputs off
// - shutdown clears by door reopen or power cycle
// - internal faults disable outputs immediately
// - control input faults reported, a and b differing also unlocks
// - warning clears when its cause disappears
// - power, status and fault indicators driven
// - fault codes one to seven as pulse counts
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "icl_defines.svh"
module icl_ctrl import icl_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `ICL_TICK_CYCLES,
  parameter int unsigned HOLD_TICKS = `ICL_TEACH_HOLD_TICKS,
  parameter int unsigned PWR_OFF_TICKS = `ICL_PWR_OFF_TICKS,
  parameter int unsigned INHIBIT_TICKS = `ICL_INHIBIT_TICKS,
  parameter int unsigned WARN_TICKS = `ICL_WARN_TICKS
) (
  input wire logic core_clk_i, // 25 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [1:0] reg_addr_i, // register address
  input wire logic [31:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic ctrl_in_a_i, // lock command channel a
  input wire logic ctrl_in_b_i, // lock command channel b
  input wire logic ctrl_in_c_i, // electronic release request
  input wire logic single_teach_variant_i, // one-time pairing build
  input wire logic multi_teach_variant_i, // reteachable build
  input wire logic act_present_i, // actuator in detection range
  input wire logic act_known_i, // actuator code equals stored code
  input wire logic det_fault_i, // actuator detection fault
  input wire logic ch_a_fault_i, // output channel a fault
  input wire logic ch_b_fault_i, // output channel b fault
  input wire logic xshort_i, // cross-short between outputs
  input wire logic overtemp_i, // internal temperature too high
  input wire logic internal_fault_i, // fault compromising safe function
  input wire logic nv_teach_pend_i, // stored: code learned, not active
  input wire logic nv_inhibit_pend_i, // stored: inhibit was running
  input wire logic nv_paired_i, // stored: single variant paired
  output logic nv_teach_pend_o, // store learned-code pending flag
  output logic nv_inhibit_pend_o, // store inhibit-running flag
  output logic nv_paired_o, // store permanent pairing
  output logic code_learn_o, // pulse: latch the present code
  output logic code_commit_o, // pulse: activate learned code
  output logic safety_out_a_o, // safety output channel a
  output logic safety_out_b_o, // safety output channel b
  output logic diag_status_first_o, // diagnostic output 1
  output logic diag_status_second_o, // diagnostic output 2
  output logic led_power_o, // green indicator
  output logic led_status_o, // yellow indicator
  output logic led_fault_o // red indicator
);
  // ***********************************************
  // reset release and shared plumbing
  // ***********************************************
  logic rst_q1, rst_n;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  icl_core_if cif ();
  icl_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .bus(cif.tb)
  );
  icl_sync u_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .bus(cif.sy)
  );
  assign cif.raw = {ctrl_in_a_i, ctrl_in_b_i, ctrl_in_c_i, single_teach_variant_i,
                    multi_teach_variant_i, act_present_i, act_known_i, det_fault_i,
                    ch_a_fault_i, ch_b_fault_i, xshort_i, overtemp_i, internal_fault_i};
  logic in_a, in_b, in_c, var_single, var_multi, present, known;
  logic det_f, cha_f, chb_f, xs_f, temp_f, int_f;
  assign {in_a, in_b, in_c, var_single, var_multi, present, known,
          det_f, cha_f, chb_f, xs_f, temp_f, int_f} = cif.ins;
  wire tick = cif.tick;

  // ***********************************************
  // register port
  // ***********************************************
  logic teach_en;
  icl_state_e state;
  icl_code_t code;
  logic warn, shut, safe_on;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      teach_en <= `ICL_CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == `ICL_REG_CTRL) begin
      teach_en <= reg_wdata_i[0];
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i && reg_addr_i == `ICL_REG_CTRL) begin
      reg_rdata_o <= {31'h0, teach_en};
    end else if (reg_rd_i && reg_addr_i == `ICL_REG_STATUS) begin
      reg_rdata_o <= {21'h0, safe_on, shut, warn, 1'h0, code, 1'h0, state};
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ***********************************************
  // actuator arrival edge detection
  // ***********************************************
  logic boot_done, first_det;
  logic present_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      present_q <= 1'b0;
    end else begin
      present_q <= present;
    end
  end
  wire arrive = present & ~present_q;

  // ***********************************************
  // teach sequencer
  // ***********************************************
  logic [`ICL_TMR_W-1:0] tmr;
  logic act_fault;
  wire can_teach = teach_en & ~known & (var_multi | (var_single & ~nv_paired_o));
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ICL_BOOT;
      tmr <= '0;
      first_det <= 1'b1;
      boot_done <= 1'b0;
      nv_teach_pend_o <= 1'b0;
      nv_inhibit_pend_o <= 1'b0;
      nv_paired_o <= 1'b0;
      code_learn_o <= 1'b0;
      code_commit_o <= 1'b0;
      act_fault <= 1'b0;
    end else begin
      code_learn_o <= 1'b0;
      code_commit_o <= 1'b0;
      if (tick) begin
        tmr <= tmr + `ICL_TMR_W'(1);
      end
      if (arrive) begin
        first_det <= 1'b0;
      end
      case (state)
        ICL_BOOT: begin
          boot_done <= 1'b1;
          if (boot_done) begin
            nv_teach_pend_o <= nv_teach_pend_i;
            nv_inhibit_pend_o <= nv_inhibit_pend_i;
            nv_paired_o <= nv_paired_i;
            tmr <= '0;
            if (nv_teach_pend_i) begin
              state <= ICL_ACTIVATE;
            end else if (nv_inhibit_pend_i) begin
              state <= ICL_INHIBIT;
            end else begin
              state <= ICL_RUN;
            end
          end
        end
        ICL_RUN: begin
          tmr <= '0;
          if (arrive && first_det && can_teach) begin
            state <= ICL_TEACH;
          end
        end
        ICL_TEACH: begin
          if (!present) begin
            state <= ICL_RUN;
          end else if (tmr >= `ICL_TMR_W'(HOLD_TICKS)) begin
            tmr <= '0;
            code_learn_o <= 1'b1;
            nv_teach_pend_o <= 1'b1;
            state <= ICL_TEACH_REQ;
          end
        end
        ICL_TEACH_REQ: begin
          if (tmr >= `ICL_TMR_W'(PWR_OFF_TICKS)) begin
            nv_teach_pend_o <= 1'b0;
            act_fault <= 1'b1;
            state <= ICL_ABORT;
          end
        end
        ICL_ABORT: begin
          state <= ICL_ABORT;
        end
        ICL_ACTIVATE: begin
          if (present) begin
            code_commit_o <= 1'b1;
            nv_teach_pend_o <= 1'b0;
            tmr <= '0;
            if (var_multi) begin
              nv_inhibit_pend_o <= 1'b1;
              state <= ICL_INHIBIT;
            end else begin
              nv_paired_o <= 1'b1;
              state <= ICL_RUN;
            end
          end
        end
        ICL_INHIBIT: begin
          if (tmr >= `ICL_TMR_W'(INHIBIT_TICKS) && present) begin
            nv_inhibit_pend_o <= 1'b0;
            state <= ICL_RUN;
          end
        end
        default: begin
          state <= ICL_BOOT;
        end
      endcase
    end
  end

  // ***********************************************
  // lock command and fault handling
  // ***********************************************
  logic locked, door_opened;
  logic [`ICL_TMR_W-1:0] wtmr;
  wire lock_cmd = in_a & in_b;
  wire ctrl_bad = in_a ^ in_b;
  wire noncrit = cha_f | chb_f | xs_f | temp_f;
  wire crit = int_f | det_f | act_fault;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      locked <= 1'b0;
    end else if (!lock_cmd || in_c) begin
      locked <= 1'b0;
    end else if (present) begin
      locked <= 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      warn <= 1'b0;
      wtmr <= '0;
    end else if (!noncrit) begin
      warn <= 1'b0;
      wtmr <= '0;
    end else begin
      if (safe_on) begin
        warn <= 1'b1;
      end
      if (warn && tick && wtmr < `ICL_TMR_W'(WARN_TICKS)) begin
        wtmr <= wtmr + `ICL_TMR_W'(1);
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shut <= 1'b0;
      door_opened <= 1'b0;
    end else if (warn && wtmr >= `ICL_TMR_W'(WARN_TICKS)) begin
      shut <= 1'b1;
      door_opened <= 1'b0;
    end else if (shut) begin
      if (!present) begin
        door_opened <= 1'b1;
      end else if (door_opened && !noncrit) begin
        shut <= 1'b0;
        door_opened <= 1'b0;
      end
    end
  end
  // ctrl_bad feeds only the fault code, never the enable
  wire next_safe = (state == ICL_RUN) & locked & present & known & ~shut & ~crit;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      safe_on <= 1'b0;
      safety_out_a_o <= 1'b0;
      safety_out_b_o <= 1'b0;
    end else begin
      safe_on <= next_safe;
      safety_out_a_o <= next_safe;
      safety_out_b_o <= next_safe;
    end
  end

  // ***********************************************
  // fault code selection
  // ***********************************************
  always_comb begin
    code = 3'h0;
    if (det_f) code = 3'h7;
    if (ctrl_bad) code = 3'h6;
    if (act_fault) code = 3'h5;
    if (temp_f) code = 3'h4;
    if (xs_f || (cha_f && chb_f)) code = 3'h3;
    else if (chb_f) code = 3'h2;
    else if (cha_f) code = 3'h1;
  end

  // ***********************************************
  // blink phases and flash-code generator
  // ***********************************************
  logic [10:0] ph_slow, ph_fast, ph_fl;
  logic [2:0] fl_cnt;
  logic fl_gap;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ph_slow <= 11'h0;
      ph_fast <= 11'h0;
    end else if (tick) begin
      ph_slow <= (ph_slow == `ICL_SLOW_PERIOD - 11'h1) ? 11'h0 : ph_slow + 11'h1;
      ph_fast <= (ph_fast == `ICL_FAST_PERIOD - 11'h1) ? 11'h0 : ph_fast + 11'h1;
    end
  end
  wire slow_on = ph_slow < `ICL_SLOW_ON;
  wire fast_on = ph_fast < `ICL_FAST_ON;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ph_fl <= 11'h0;
      fl_cnt <= 3'h0;
      fl_gap <= 1'b1;
    end else if (tick) begin
      ph_fl <= ph_fl + 11'h1;
      if (fl_gap) begin
        if (ph_fl >= `ICL_FLASH_GAP - 11'h1) begin
          ph_fl <= 11'h0;
          fl_cnt <= 3'h0;
          fl_gap <= (code == 3'h0);
        end
      end else if (ph_fl >= (`ICL_FLASH_HALF << 1) - 11'h1) begin
        ph_fl <= 11'h0;
        fl_cnt <= fl_cnt + 3'h1;
        if (fl_cnt + 3'h1 >= code) begin
          fl_gap <= 1'b1;
        end
      end
    end
  end
  wire flash = ~fl_gap & (ph_fl < `ICL_FLASH_HALF);

  // ***********************************************
  // indicators and diagnostic outputs
  // ***********************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      led_power_o <= 1'b0;
      led_status_o <= 1'b0;
      led_fault_o <= 1'b0;
      diag_status_first_o <= 1'b0;
      diag_status_second_o <= 1'b0;
    end else begin
      case (state)
        ICL_TEACH: begin
          led_power_o <= 1'b0;
          led_fault_o <= 1'b1;
          led_status_o <= slow_on;
        end
        ICL_TEACH_REQ: begin
          led_power_o <= 1'b0;
          led_fault_o <= 1'b1;
          led_status_o <= fast_on;
        end
        ICL_INHIBIT: begin
          led_power_o <= slow_on;
          led_fault_o <= 1'b0;
          led_status_o <= 1'b0;
        end
        default: begin
          led_power_o <= 1'b1;
          led_fault_o <= int_f | flash;
          led_status_o <= safe_on | (locked & slow_on);
        end
      endcase
      // these are status only, never safety decisions
      diag_status_first_o <= (safe_on | shut) & (state == ICL_RUN);
      diag_status_second_o <= (state == ICL_INHIBIT) |
                              (safe_on & ~warn & ~shut & ~crit);
    end
  end
endmodule : icl_ctrl

// *** core/icl_defines.svh ***
// constants for the interlock teach and safety controller
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH
// ***********************************************
// time base
// ***********************************************
`define ICL_CLK_MHZ 25
`define ICL_TICK_US 1000
`define ICL_TICK_CYCLES (`ICL_TICK_US * `ICL_CLK_MHZ)
`define ICL_TICKS_PER_S (1000000 / `ICL_TICK_US)
// ***********************************************
// sequence times
// ***********************************************
`define ICL_TEACH_HOLD_S 10
`define ICL_PWR_OFF_MIN 5
`define ICL_INHIBIT_MIN 10
`define ICL_WARN_MIN 30
`define ICL_TEACH_HOLD_TICKS (`ICL_TEACH_HOLD_S * `ICL_TICKS_PER_S)
`define ICL_PWR_OFF_TICKS (`ICL_PWR_OFF_MIN * 60 * `ICL_TICKS_PER_S)
`define ICL_INHIBIT_TICKS (`ICL_INHIBIT_MIN * 60 * `ICL_TICKS_PER_S)
`define ICL_WARN_TICKS (`ICL_WARN_MIN * 60 * `ICL_TICKS_PER_S)
// ***********************************************
// blink and flash timing, in ticks
// ***********************************************
`define ICL_SLOW_PERIOD 11'h3E8
`define ICL_SLOW_ON 11'h1F4
`define ICL_FAST_PERIOD 11'h14D
`define ICL_FAST_ON 11'h032
`define ICL_FLASH_HALF 11'h0FA
`define ICL_FLASH_GAP 11'h5DC
// ***********************************************
// register map
// ***********************************************
`define ICL_REG_CTRL 2'h0
`define ICL_REG_STATUS 2'h1
`define ICL_CTRL_RESET 1'h1
`define ICL_TMR_W 21
`define ICL_IN_W 13
`endif

// *** core/icl_pkg.sv ***
// types of the interlock teach and safety controller
package icl_pkg;
  typedef enum logic [2:0] {
    ICL_BOOT,
    ICL_RUN,
    ICL_TEACH,
    ICL_TEACH_REQ,
    ICL_ABORT,
    ICL_ACTIVATE,
    ICL_INHIBIT
  } icl_state_e;
  typedef logic [2:0] icl_code_t;
endpackage : icl_pkg

// *** core/icl_sync.sv ***
// three-stage synchronisers for the pin inputs
`timescale 1ns/10ps
`include "icl_defines.svh"
module icl_sync (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // synchronised reset
  icl_core_if.sy bus // raw in, clean out
);
  genvar i;
  generate
    for (i = 0; i < `ICL_IN_W; i++) begin : g_bit
      logic s1, s2, s3;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          bus.ins[i] <= 1'b0;
        end else begin
          s1 <= bus.raw[i];
          s2 <= s1;
          s3 <= s2;
          // a change counts once the last two stages agree
          if (s2 == s3) begin
            bus.ins[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule : icl_sync

// *** core/icl_timebase.sv ***
// divider making the one-cycle time base tick
`timescale 1ns/10ps
`include "icl_defines.svh"
module icl_timebase #(
  parameter int unsigned TICK_CYCLES = `ICL_TICK_CYCLES
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // synchronised reset
  icl_core_if.tb bus // tick out
);
  logic [31:0] cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 32'h0;
      bus.tick <= 1'b0;
    end else if (cnt >= TICK_CYCLES - 1) begin
      cnt <= 32'h0;
      bus.tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      bus.tick <= 1'b0;
    end
  end
endmodule : icl_timebase

// *** test/icl_ctrl_properties.sv ***
// port checks of the interlock controller
`timescale 1ns/10ps
module icl_ctrl_properties (
  input wire logic core_clk_i, // core clock
  input wire logic nrst_i, // reset, active low
  input wire logic ctrl_in_c_i, // release request
  input wire logic act_present_i, // actuator in range
  input wire logic ch_a_fault_i, // channel a fault
  input wire logic ch_b_fault_i, // channel b fault
  input wire logic xshort_i, // cross-short
  input wire logic overtemp_i, // overtemperature
  input wire logic internal_fault_i, // internal fault
  input wire logic code_learn_o, // learn pulse
  input wire logic code_commit_o, // commit pulse
  input wire logic nv_teach_pend_o, // pending flag
  input wire logic safety_out_a_o, // safety output a
  input wire logic safety_out_b_o, // safety output b
  input wire logic diag_status_first_o, // diagnostic 1
  input wire logic diag_status_second_o, // diagnostic 2
  input wire logic led_power_o, // green
  input wire logic led_fault_o // red
);
  default clocking dflt @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  chk_chan_match: assert property (safety_out_a_o == safety_out_b_o)
    else $error("safety channels differ");
  chk_release_off: assert property (ctrl_in_c_i [*8] |-> !safety_out_a_o)
    else $error("outputs on during release");
  chk_internal_off: assert property (internal_fault_i [*6] |-> !safety_out_a_o)
    else $error("outputs on with internal fault");
  chk_absent_off: assert property (!act_present_i [*6] |-> !safety_out_a_o)
    else $error("outputs on without actuator");
  chk_learn_pend: assert property (code_learn_o |-> ##[0:2] nv_teach_pend_o)
    else $error("learn without pending flag");
  chk_learn_leds: assert property (code_learn_o |-> (!led_power_o && led_fault_o) [*2])
    else $error("wrong leds during teach");
  chk_commit_pulse: assert property (code_commit_o |=> !code_commit_o)
    else $error("commit pulse too long");
  chk_diag_first: assert property (safety_out_a_o |-> ##[0:1] diag_status_first_o)
    else $error("diagnostic 1 low with outputs on");
  chk_warn_clear: assert property ((!(ch_a_fault_i | ch_b_fault_i | xshort_i | overtemp_i)
    && safety_out_a_o) [*8] |-> ##[0:1] diag_status_second_o)
    else $error("warning stays without fault");
  cov_learn: cover property (code_learn_o);
  cov_commit: cover property (code_commit_o);
  cov_warn: cover property (safety_out_a_o && !diag_status_second_o);
endmodule : icl_ctrl_properties
bind icl_ctrl icl_ctrl_properties icl_ctrl_properties_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ctrl_in_c_i(ctrl_in_c_i),
  .act_present_i(act_present_i), .ch_a_fault_i(ch_a_fault_i), .ch_b_fault_i(ch_b_fault_i),
  .xshort_i(xshort_i), .overtemp_i(overtemp_i), .internal_fault_i(internal_fault_i),
  .code_learn_o(code_learn_o), .code_commit_o(code_commit_o),
  .nv_teach_pend_o(nv_teach_pend_o), .safety_out_a_o(safety_out_a_o),
  .safety_out_b_o(safety_out_b_o), .diag_status_first_o(diag_status_first_o),
  .diag_status_second_o(diag_status_second_o), .led_power_o(led_power_o),
  .led_fault_o(led_fault_o));

// *** test/icl_plc_model.sv ***
// plc model: issues lock commands and shows the diagnostic outputs
`timescale 1ns/10ps
module icl_plc_model (
  input wire logic clk_i, // core clock
  input wire logic lock_req_i, // bench asks for lock
  input wire logic diag_first_i, // diagnostic output 1
  input wire logic diag_second_i, // diagnostic output 2
  output logic ctrl_a_o, // lock command a
  output logic ctrl_b_o, // lock command b
  output logic [1:0] view_o // diagnostics, display only
);
  initial begin
    ctrl_a_o = 1'b0;
    ctrl_b_o = 1'b0;
    view_o = 2'h0;
  end
  // diagnostics feed the display only, never the commands
  always @(posedge clk_i) begin
    view_o <= {diag_second_i, diag_first_i};
    ctrl_a_o <= lock_req_i;
    ctrl_b_o <= lock_req_i;
  end
endmodule : icl_plc_model

// *** test/testbench.sv ***
// self-checking bench of the interlock controller
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, lock = 1'b0, rel = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic single = 1'b0, multi = 1'b1, pres = 1'b0, known = 1'b1, detf = 1'b0;
  logic chaf = 1'b0, chbf = 1'b0, xsh = 1'b0, otemp = 1'b0, intf = 1'b0;
  logic nvt = 1'b0, nvi = 1'b0, nvp = 1'b0;
  logic ca, cb, nvt_o, nvi_o, nvp_o, learn, commit, sa, sb, d1, d2, lp, ls, lf;
  int miscompares = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  icl_ctrl #(.TICK_CYCLES(4), .HOLD_TICKS(20), .PWR_OFF_TICKS(50), .INHIBIT_TICKS(50),
    .WARN_TICKS(50)) icl_ctrl_inst (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .ctrl_in_a_i(ca), .ctrl_in_b_i(cb), .ctrl_in_c_i(rel),
    .single_teach_variant_i(single), .multi_teach_variant_i(multi),
    .act_present_i(pres), .act_known_i(known), .det_fault_i(detf), .ch_a_fault_i(chaf),
    .ch_b_fault_i(chbf), .xshort_i(xsh), .overtemp_i(otemp), .internal_fault_i(intf),
    .nv_teach_pend_i(nvt), .nv_inhibit_pend_i(nvi), .nv_paired_i(nvp),
    .nv_teach_pend_o(nvt_o), .nv_inhibit_pend_o(nvi_o), .nv_paired_o(nvp_o),
    .code_learn_o(learn), .code_commit_o(commit), .safety_out_a_o(sa),
    .safety_out_b_o(sb), .diag_status_first_o(d1), .diag_status_second_o(d2),
    .led_power_o(lp), .led_status_o(ls), .led_fault_o(lf));
  icl_plc_model icl_plc_model_inst (.clk_i(clk), .lock_req_i(lock), .diag_first_i(d1),
    .diag_second_i(d2), .ctrl_a_o(ca), .ctrl_b_o(cb), .view_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  task automatic wr_reg(input logic [1:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // polls the state field, ends on a match or after lim+1 reads
  task automatic wait_st(input logic [2:0] s, input int lim);
    rd_reg(2'h1);
    for (int i = 0; i < lim && d[2:0] !== s; i++) rd_reg(2'h1);
    chk(d[2:0], s);
  endtask : wait_st
  task automatic pwr_cycle();
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(6);
  endtask : pwr_cycle
  // ****************************
  // scenarios
  // ****************************
  task automatic t_regs();
    rd_reg(2'h1);
    chk(d, 32'h1);
    chk({lp, lf}, 2'b10);
    rd_reg(2'h0);
    chk(d, 32'h1);
    wr_reg(2'h0, 32'h0);
    wr_reg(2'h2, 32'h1);
    rd_reg(2'h0);
    chk(d, 32'h0);
    rd_reg(2'h2);
    chk(d, 32'h0);
    wr_reg(2'h0, 32'h1);
  endtask : t_regs
  task automatic t_lock();
    pres <= 1'b1;
    lock <= 1'b1;
    cyc(12);
    chk({sa, sb, d1}, 3'b111);
    chk(ls, 1'b1);
    rel <= 1'b1;
    // three sync stages, the filter register, the lock flag and the output register
    cyc(8);
    chk({sa, sb}, 2'b00);
    rel <= 1'b0;
    cyc(12);
    chk({sa, sb}, 2'b11);
  endtask : t_lock
  task automatic t_warn();
    otemp <= 1'b1;
    cyc(12);
    chk({sa, d2}, 2'b10);
    rd_reg(2'h1);
    chk(d[10:4], 7'h54);
    otemp <= 1'b0;
    cyc(12);
    chk(d2, 1'b1);
    chaf <= 1'b1;
    cyc(150);
    chk(sa, 1'b1);
    cyc(80);
    chk(sa, 1'b0);
    rd_reg(2'h1);
    chk({d[9], d[6:4]}, 4'h9);
    chaf <= 1'b0;
    cyc(12);
    chk(sa, 1'b0);
    pres <= 1'b0;
    cyc(12);
    pres <= 1'b1;
    cyc(12);
    chk(sa, 1'b1);
  endtask : t_warn
  task automatic t_crit();
    for (int i = 0; i < 2; i++) begin
      intf <= (i == 0);
      detf <= (i == 1);
      cyc(6);
      chk(sa, 1'b0);
      intf <= 1'b0;
      detf <= 1'b0;
      cyc(12);
      chk(sa, 1'b1);
    end
  endtask : t_crit
  task automatic t_teach();
    int n;
    n = 0;
    pres <= 1'b0;
    known <= 1'b0;
    pwr_cycle();
    pres <= 1'b1;
    wait_st(3'h2, 20);
    chk({lp, lf}, 2'b01);
    repeat (120) begin
      @(posedge clk);
      n += learn;
    end
    chk(n, 1);
    wait_st(3'h3, 5);
    chk(nvt_o, 1'b1);
    wait_st(3'h4, 150);
    chk({sa, d[6:4]}, 4'h5);
  endtask : t_teach
  task automatic t_activate();
    int n;
    n = 0;
    nvt <= 1'b1;
    pres <= 1'b0;
    known <= 1'b1;
    pwr_cycle();
    wait_st(3'h5, 5);
    pres <= 1'b1;
    repeat (20) begin
      @(posedge clk);
      n += commit;
    end
    chk(n, 1);
    wait_st(3'h6, 5);
    chk({nvt_o, nvi_o, sa}, 3'b010);
    wait_st(3'h1, 150);
    nvt <= 1'b0;
    nvi <= 1'b1;
    pwr_cycle();
    wait_st(3'h6, 5);
    cyc(150);
    rd_reg(2'h1);
    chk(d[2:0], 3'h6);
    nvi <= 1'b0;
  endtask : t_activate
  task automatic t_single();
    single <= 1'b1;
    multi <= 1'b0;
    nvt <= 1'b1;
    pres <= 1'b0;
    pwr_cycle();
    pres <= 1'b1;
    wait_st(3'h1, 20);
    chk(nvp_o, 1'b1);
    nvt <= 1'b0;
    nvp <= 1'b1;
    known <= 1'b0;
    pres <= 1'b0;
    pwr_cycle();
    pres <= 1'b1;
    cyc(20);
    rd_reg(2'h1);
    chk(d[2:0], 3'h1);
  endtask : t_single
  task automatic results();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    cyc(2);
    nrst <= 1'b1;
    cyc(6);
    t_regs();
    t_lock();
    t_warn();
    t_crit();
    t_teach();
    t_activate();
    t_single();
    results();
  end
  initial begin
    cyc(40000);
    miscompares++;
    results();
  end
endmodule : testbench
